// ---- hw/irq_bank_pkg.sv ----
// constants, field layout and carrier types for the peripheral flag/enable bank
package irq_bank_pkg;
    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] OFF_FLAGS_TWO = 8'h00;
    localparam logic [7:0] OFF_FLAGS_THREE = 8'h04;
    localparam logic [7:0] OFF_ENABLES_ONE = 8'h08;
    localparam logic [7:0] OFF_ENABLES_TWO = 8'h0c;
    localparam logic [7:0] OFF_ENABLES_THREE = 8'h10;
    localparam logic [7:0] OFF_CONTROL = 8'h14;
    // ==========================================================
    // field positions, second flag / enable register
    localparam int BIT_OSC_FAIL = 7;
    localparam int BIT_COMPARATOR_CHANGE = 6;
    localparam int BIT_BUS_COLLISION = 3;
    localparam int BIT_LOW_VOLTAGE = 2;
    localparam int BIT_TIMER_THREE_OVERFLOW = 1;
    // field positions, third flag / enable register
    localparam int BIT_DISPLAY_FRAME = 6;
    localparam int BIT_SERIAL_B_RX = 5;
    localparam int BIT_SERIAL_B_TX = 4;
    localparam int BIT_CHARGE_TIME = 3;
    localparam int BIT_CAPCOMP_B = 2;
    localparam int BIT_CAPCOMP_A = 1;
    localparam int BIT_RTC_EVENT = 0;
    // field positions, control register
    localparam int BIT_PERIPHERAL_GLOBAL_ENABLE = 0;
    localparam int BIT_PRIORITY_LEVELS_ENABLE = 1;
    // ==========================================================
    // implemented / writable bit masks and reset values
    localparam logic [7:0] MASK_ONE = 8'h7b;
    localparam logic [7:0] MASK_TWO = 8'hce;
    localparam logic [7:0] MASK_THREE = 8'h7f;
    localparam logic [7:0] SW_MASK_THREE = 8'h4f;
    localparam logic [7:0] MASK_CONTROL = 8'h03;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // ==========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // carrier types
    typedef enum logic [1:0] {
        CC_OFF = 2'h0,
        CC_CAPTURE = 2'h1,
        CC_COMPARE = 2'h3,
        CC_PWM = 2'h2
    } capcomp_mode_t;

    typedef struct packed {
        logic osc_fail;
        logic comparator_change;
        logic bus_collision;
        logic low_voltage;
        logic timer_three_overflow;
        logic display_frame;
        logic display_type_b_nonstatic;
        logic serial_b_rx_full;
        logic serial_b_tx_empty;
        logic charge_time;
        logic capcomp_a_capture;
        logic capcomp_a_match;
        capcomp_mode_t capcomp_a_mode;
        logic capcomp_b_capture;
        logic capcomp_b_match;
        capcomp_mode_t capcomp_b_mode;
        logic rtc_event;
    } events_t;

    typedef struct packed {
        logic [7:0] one;
        logic [7:0] two;
        logic [7:0] three;
    } byte_trio_t;
endpackage : irq_bank_pkg

// ---- hw/periph_irq_flag_enable_bank.sv ----
// peripheral interrupt flag and enable bank with AXI4-Lite register access
//
// How it works
// - oscillator failure sets sticky flag bit 7
// - comparator change sets sticky flag bit 6
// - bus collision sets sticky flag bit 3
// - low voltage sets flag, never self-clears
// - third timer overflow sets flag bit 1
// - unimplemented bits read zero, ignore writes
// - display flag set only in type-B non-static
// - serial B rx flag: read-only buffer-full level
// - serial B tx flag: read-only buffer-empty level
// - charge-time event sets flag bit 3
// - capture event sets capcomp flag in capture
// - compare match sets flag; pwm never sets
// - real-time clock event sets flag bit 0
// - without priorities, global enable gates all
// - three enable registers, reset to zero
// - enable bit gates the same-position flag
// - priority bits act only with priorities on
// - flags set regardless of any enable
// - with priorities, global enable gates low only
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module periph_irq_flag_enable_bank #(
    parameter int ADDR_W = 8
) (
    input wire logic I_REF_CLK, // 200 MHz system clock
    input wire logic I_RESET_N, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] I_AWADDR, // write address
    input wire logic I_AWVALID, // write address valid
    output logic O_AWREADY, // write address ready
    input wire logic [31:0] I_WDATA, // write data
    input wire logic [3:0] I_WSTRB, // write byte strobes
    input wire logic I_WVALID, // write data valid
    output logic O_WREADY, // write data ready
    output logic [1:0] O_BRESP, // write response
    output logic O_BVALID, // write response valid
    input wire logic I_BREADY, // write response ready
    input wire logic [ADDR_W-1:0] I_ARADDR, // read address
    input wire logic I_ARVALID, // read address valid
    output logic O_ARREADY, // read address ready
    output logic [31:0] O_RDATA, // read data
    output logic [1:0] O_RRESP, // read response
    output logic O_RVALID, // read data valid
    input wire logic I_RREADY, // read data ready
    input wire irq_bank_pkg::events_t I_EVENTS, // peripheral event pulses and levels
    input wire logic [7:0] I_FLAGS_ONE, // first flag register, held next door
    input wire irq_bank_pkg::byte_trio_t I_PRIORITY, // per-source priority bits
    output logic O_IRQ_LOW, // peripheral request, low or single level
    output logic O_IRQ_HIGH // peripheral request, high priority
);
    // ==========================================================
    // helpers
    function automatic logic any_hit(input logic [7:0] f, input logic [7:0] e,
                                     input logic [7:0] sel);
        any_hit = |(f & e & sel);
    endfunction : any_hit

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= ADDR_W'(irq_bank_pkg::OFF_CONTROL));
    endfunction : is_mapped

    // ==========================================================
    // state
    logic [7:0] flags_two_q, flags_two_d;
    logic [7:0] flags_three_q, flags_three_d;
    logic [7:0] enables_one_q, enables_one_d;
    logic [7:0] enables_two_q, enables_two_d;
    logic [7:0] enables_three_q, enables_three_d;
    logic [7:0] control_q, control_d;
    logic aw_have_q, w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic irq_low_q, irq_high_q;

    // ==========================================================
    // write channel decode
    wire aw_take = I_AWVALID && awready_q;
    wire w_take = I_WVALID && wready_q;
    wire do_write = aw_have_q && w_have_q && !bvalid_q;
    wire wr_ok = do_write && w_lane_q && is_mapped(aw_addr_q);
    wire wr_two = wr_ok && (aw_addr_q == ADDR_W'(irq_bank_pkg::OFF_FLAGS_TWO));
    wire wr_three = wr_ok && (aw_addr_q == ADDR_W'(irq_bank_pkg::OFF_FLAGS_THREE));
    wire wr_en_one = wr_ok && (aw_addr_q == ADDR_W'(irq_bank_pkg::OFF_ENABLES_ONE));
    wire wr_en_two = wr_ok && (aw_addr_q == ADDR_W'(irq_bank_pkg::OFF_ENABLES_TWO));
    wire wr_en_three = wr_ok && (aw_addr_q == ADDR_W'(irq_bank_pkg::OFF_ENABLES_THREE));
    wire wr_control = wr_ok && (aw_addr_q == ADDR_W'(irq_bank_pkg::OFF_CONTROL));

    // ==========================================================
    // hardware set terms; flags latch whatever the enables hold
    logic [7:0] set_two, set_three;
    wire cc_a_set = (I_EVENTS.capcomp_a_mode == irq_bank_pkg::CC_CAPTURE
                     && I_EVENTS.capcomp_a_capture)
                    || (I_EVENTS.capcomp_a_mode == irq_bank_pkg::CC_COMPARE
                     && I_EVENTS.capcomp_a_match);
    wire cc_b_set = (I_EVENTS.capcomp_b_mode == irq_bank_pkg::CC_CAPTURE
                     && I_EVENTS.capcomp_b_capture)
                    || (I_EVENTS.capcomp_b_mode == irq_bank_pkg::CC_COMPARE
                     && I_EVENTS.capcomp_b_match);
    wire disp_set = I_EVENTS.display_frame && I_EVENTS.display_type_b_nonstatic;

    always_comb begin
        set_two = 8'h00;
        set_two[irq_bank_pkg::BIT_OSC_FAIL] = I_EVENTS.osc_fail;
        set_two[irq_bank_pkg::BIT_COMPARATOR_CHANGE] = I_EVENTS.comparator_change;
        set_two[irq_bank_pkg::BIT_BUS_COLLISION] = I_EVENTS.bus_collision;
        set_two[irq_bank_pkg::BIT_LOW_VOLTAGE] = I_EVENTS.low_voltage;
        set_two[irq_bank_pkg::BIT_TIMER_THREE_OVERFLOW] = I_EVENTS.timer_three_overflow;
        set_three = 8'h00;
        set_three[irq_bank_pkg::BIT_DISPLAY_FRAME] = disp_set;
        set_three[irq_bank_pkg::BIT_CHARGE_TIME] = I_EVENTS.charge_time;
        set_three[irq_bank_pkg::BIT_CAPCOMP_B] = cc_b_set;
        set_three[irq_bank_pkg::BIT_CAPCOMP_A] = cc_a_set;
        set_three[irq_bank_pkg::BIT_RTC_EVENT] = I_EVENTS.rtc_event;
    end

    // ==========================================================
    // next values; set is or-ed after the write so an event is never lost
    wire [7:0] wbyte = w_byte_q;
    wire [7:0] rx_tx_lvl = (8'(I_EVENTS.serial_b_rx_full) << irq_bank_pkg::BIT_SERIAL_B_RX)
                         | (8'(I_EVENTS.serial_b_tx_empty) << irq_bank_pkg::BIT_SERIAL_B_TX);
    assign flags_two_d = ((wr_two ? wbyte : flags_two_q) | set_two)
                         & irq_bank_pkg::MASK_TWO;
    assign flags_three_d = (((wr_three ? wbyte : flags_three_q) | set_three)
                            & irq_bank_pkg::SW_MASK_THREE)
                           | rx_tx_lvl;
    assign enables_one_d = wr_en_one ? (wbyte & irq_bank_pkg::MASK_ONE)
                                     : enables_one_q;
    assign enables_two_d = wr_en_two ? (wbyte & irq_bank_pkg::MASK_TWO)
                                     : enables_two_q;
    assign enables_three_d = wr_en_three ? (wbyte & irq_bank_pkg::MASK_THREE)
                                         : enables_three_q;
    assign control_d = wr_control ? (wbyte & irq_bank_pkg::MASK_CONTROL) : control_q;

    // ==========================================================
    // request routing; enables mask per position, global enable gates the low request only
    wire peripheral_global_enable = control_q[irq_bank_pkg::BIT_PERIPHERAL_GLOBAL_ENABLE];
    wire priority_levels_enable = control_q[irq_bank_pkg::BIT_PRIORITY_LEVELS_ENABLE];
    wire [7:0] prio_one = priority_levels_enable ? I_PRIORITY.one : 8'h00;
    wire [7:0] prio_two = priority_levels_enable ? I_PRIORITY.two : 8'h00;
    wire [7:0] prio_three = priority_levels_enable ? I_PRIORITY.three : 8'h00;
    wire low_hit = any_hit(I_FLAGS_ONE & irq_bank_pkg::MASK_ONE, enables_one_q, ~prio_one)
                 || any_hit(flags_two_q, enables_two_q, ~prio_two)
                 || any_hit(flags_three_q, enables_three_q, ~prio_three);
    wire high_hit = any_hit(I_FLAGS_ONE & irq_bank_pkg::MASK_ONE, enables_one_q, prio_one)
                  || any_hit(flags_two_q, enables_two_q, prio_two)
                  || any_hit(flags_three_q, enables_three_q, prio_three);
    // the global enable gates everything in single-level mode, low priority otherwise
    wire irq_low_d = peripheral_global_enable && low_hit;
    // high-priority requests bypass the peripheral enable; the core applies its own gate
    wire irq_high_d = priority_levels_enable && high_hit;

    // ==========================================================
    // read mux
    logic [7:0] rd_byte;
    always_comb begin
        case (I_ARADDR[ADDR_W-1:0])
            ADDR_W'(irq_bank_pkg::OFF_FLAGS_TWO): rd_byte = flags_two_q;
            ADDR_W'(irq_bank_pkg::OFF_FLAGS_THREE): rd_byte = flags_three_q;
            ADDR_W'(irq_bank_pkg::OFF_ENABLES_ONE): rd_byte = enables_one_q;
            ADDR_W'(irq_bank_pkg::OFF_ENABLES_TWO): rd_byte = enables_two_q;
            ADDR_W'(irq_bank_pkg::OFF_ENABLES_THREE): rd_byte = enables_three_q;
            ADDR_W'(irq_bank_pkg::OFF_CONTROL): rd_byte = control_q;
            default: rd_byte = 8'h00;
        endcase
    end
    wire ar_take = I_ARVALID && arready_q;

    // ==========================================================
    // register file
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            flags_two_q <= irq_bank_pkg::RESET_VALUE;
            flags_three_q <= irq_bank_pkg::RESET_VALUE;
            enables_one_q <= irq_bank_pkg::RESET_VALUE;
            enables_two_q <= irq_bank_pkg::RESET_VALUE;
            enables_three_q <= irq_bank_pkg::RESET_VALUE;
            control_q <= irq_bank_pkg::RESET_VALUE;
            irq_low_q <= 1'b0;
            irq_high_q <= 1'b0;
        end else begin
            flags_two_q <= flags_two_d;
            flags_three_q <= flags_three_d;
            enables_one_q <= enables_one_d;
            enables_two_q <= enables_two_d;
            enables_three_q <= enables_three_d;
            control_q <= control_d;
            irq_low_q <= irq_low_d;
            irq_high_q <= irq_high_d;
        end
    end

    // ==========================================================
    // AXI4-Lite write side: address and data may arrive in either order
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q <= 8'h00;
            w_lane_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= irq_bank_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= I_AWADDR;
                awready_q <= 1'b0;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_byte_q <= I_WDATA[7:0];
                w_lane_q <= I_WSTRB[0];
                wready_q <= 1'b0;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(aw_addr_q) ? irq_bank_pkg::RESP_OKAY
                                                : irq_bank_pkg::RESP_SLVERR;
            end
            if (bvalid_q && I_BREADY) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read side: one read in flight
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= irq_bank_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= is_mapped(I_ARADDR) ? irq_bank_pkg::RESP_OKAY
                                           : irq_bank_pkg::RESP_SLVERR;
        end else if (rvalid_q && I_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign O_AWREADY = awready_q;
    assign O_WREADY = wready_q;
    assign O_BVALID = bvalid_q;
    assign O_BRESP = bresp_q;
    assign O_ARREADY = arready_q;
    assign O_RVALID = rvalid_q;
    assign O_RDATA = rdata_q;
    assign O_RRESP = rresp_q;
    assign O_IRQ_LOW = irq_low_q;
    assign O_IRQ_HIGH = irq_high_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence s_both_taken;
        aw_have_q && w_have_q && !bvalid_q;
    endsequence
    sequence s_resp_up;
        bvalid_q;
    endsequence

    a_set_beats_clear: assert property (
        (wr_two && I_EVENTS.low_voltage) |=> flags_two_q[irq_bank_pkg::BIT_LOW_VOLTAGE])
        else $error("low-voltage event lost under a clearing write");
    a_low_voltage_holds: assert property (
        (flags_two_q[irq_bank_pkg::BIT_LOW_VOLTAGE] && !wr_two)
        |=> flags_two_q[irq_bank_pkg::BIT_LOW_VOLTAGE])
        else $error("low-voltage flag dropped without a write");
    a_unimpl_zero: assert property (
        ((flags_two_q & ~irq_bank_pkg::MASK_TWO) == 8'h00)
        && ((enables_one_q & ~irq_bank_pkg::MASK_ONE) == 8'h00)
        && !flags_three_q[7])
        else $error("unimplemented bit reads as one");
    a_rx_level_track: assert property (
        flags_three_q[irq_bank_pkg::BIT_SERIAL_B_RX] == $past(I_EVENTS.serial_b_rx_full))
        else $error("serial rx flag not following buffer level");
    a_pwm_no_flag: assert property (
        (I_EVENTS.capcomp_a_mode == irq_bank_pkg::CC_PWM && !wr_three
         && !flags_three_q[irq_bank_pkg::BIT_CAPCOMP_A])
        |=> !flags_three_q[irq_bank_pkg::BIT_CAPCOMP_A])
        else $error("capcomp flag set in pwm mode");
    a_global_gate: assert property (
        (!peripheral_global_enable && !priority_levels_enable) |=> !O_IRQ_LOW && !O_IRQ_HIGH)
        else $error("request forwarded with global enable clear");
    a_request_raise: assert property (
        (peripheral_global_enable && !priority_levels_enable && flags_two_q[irq_bank_pkg::BIT_OSC_FAIL]
         && enables_two_q[irq_bank_pkg::BIT_OSC_FAIL]) |=> O_IRQ_LOW)
        else $error("enabled flag did not raise a request");
    a_write_answer: assert property (
        s_both_taken |=> s_resp_up)
        else $error("write response late");
    a_flag_ignores_enable: assert property (
        (I_EVENTS.rtc_event && !enables_three_q[irq_bank_pkg::BIT_RTC_EVENT])
        |=> flags_three_q[irq_bank_pkg::BIT_RTC_EVENT])
        else $error("rtc flag not set while disabled");
endmodule : periph_irq_flag_enable_bank

// ---- testbench/event_source_model.sv ----
// partner model: peripheral event sources feeding the flag bank
`timescale 1ns/1ps
module event_source_model (
    input wire logic i_clk, // system clock
    input wire logic i_fire, // one-cycle request to emit the pulses held in i_req
    input wire irq_bank_pkg::events_t i_req, // wanted pulses and levels
    output irq_bank_pkg::events_t o_events // events toward the bank
);
    // ==========================================================
    // levels pass at all times, pulse fields only in the fired cycle
    logic fire_q = 1'b0;
    irq_bank_pkg::events_t level_mask;
    always_comb begin
        level_mask = '0;
        level_mask.display_type_b_nonstatic = 1'b1;
        level_mask.serial_b_rx_full = 1'b1;
        level_mask.serial_b_tx_empty = 1'b1;
        level_mask.capcomp_a_mode = irq_bank_pkg::CC_COMPARE;
        level_mask.capcomp_b_mode = irq_bank_pkg::CC_COMPARE;
    end
    // launched from a clock edge and held one full cycle, as a real source does
    always @(posedge i_clk) begin
        fire_q <= i_fire;
    end
    assign o_events = fire_q ? i_req : irq_bank_pkg::events_t'(i_req & level_mask);
endmodule : event_source_model

// ---- testbench/testbench.sv ----
// self-checking testbench for the peripheral flag and enable bank
`timescale 1ns/1ps
module testbench;
    typedef struct {
        int code;
        bit three;
        logic [7:0] exp;
    } row_t;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fire;
    logic awready, wready, bvalid, arready, rvalid, irq_low, irq_high;
    logic [7:0] awaddr, araddr, flags_one;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    irq_bank_pkg::events_t req, events;
    irq_bank_pkg::byte_trio_t prio;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [7:0] masks[5] = '{irq_bank_pkg::MASK_TWO, irq_bank_pkg::SW_MASK_THREE,
        irq_bank_pkg::MASK_ONE, irq_bank_pkg::MASK_TWO, irq_bank_pkg::MASK_THREE};
    // one event per row; the last three must be refused by mode or qualifier
    row_t rows[15] = '{'{0, 0, 8'h80}, '{1, 0, 8'h40}, '{2, 0, 8'h08}, '{3, 0, 8'h04},
        '{4, 0, 8'h02}, '{5, 1, 8'h40}, '{6, 1, 8'h08}, '{7, 1, 8'h04}, '{8, 1, 8'h02},
        '{9, 1, 8'h04}, '{10, 1, 8'h02}, '{11, 1, 8'h01}, '{12, 1, 8'h00},
        '{13, 1, 8'h00}, '{14, 1, 8'h00}};
    // ==========================================================
    // clock, design and far side
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    periph_irq_flag_enable_bank DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n),
        .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
        .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
        .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
        .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready), .I_EVENTS(events), .I_FLAGS_ONE(flags_one), .I_PRIORITY(prio),
        .O_IRQ_LOW(irq_low), .O_IRQ_HIGH(irq_high));
    event_source_model src (.i_clk(clk), .i_fire(fire), .i_req(req), .o_events(events));
    // ==========================================================
    // helpers
    function automatic irq_bank_pkg::events_t mk(input int code);
        irq_bank_pkg::events_t e;
        e = '0;
        e.capcomp_a_mode = (code == 13) ? irq_bank_pkg::CC_PWM : irq_bank_pkg::CC_CAPTURE;
        if (code == 9 || code == 10) e.capcomp_a_mode = irq_bank_pkg::CC_COMPARE;
        e.capcomp_b_mode = e.capcomp_a_mode;
        case (code)
            0: e.osc_fail = 1'b1;
            1: e.comparator_change = 1'b1;
            2: e.bus_collision = 1'b1;
            3: e.low_voltage = 1'b1;
            4: e.timer_three_overflow = 1'b1;
            5: e.display_type_b_nonstatic = 1'b1;
            6: e.charge_time = 1'b1;
            7: e.capcomp_b_capture = 1'b1;
            8, 13: e.capcomp_a_capture = 1'b1;
            9: e.capcomp_b_match = 1'b1;
            10, 14: e.capcomp_a_match = 1'b1;
            11: e.rtc_event = 1'b1;
            default: ;
        endcase
        if (code == 5 || code == 12) e.display_frame = 1'b1;
        return e;
    endfunction : mk
    task automatic final_report;
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    task automatic hang;
        n_mismatch++;
        final_report();
    endtask : hang
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
        end
    endtask : check
    // ev launches the pulses in req so that they land with the register update
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ev);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fire <= ev;
        do begin
            @(posedge clk);
            fire <= 1'b0;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        resp = bresp;
        if (!bvalid) hang();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 40);
        rready <= 1'b0;
        got = rdata;
        resp = rresp;
        if (!rvalid) hang();
    endtask : rd
    task automatic irq_is(input logic lo, input logic hi);
        repeat (3) @(posedge clk);
        check({30'h0, irq_low, irq_high}, {30'h0, lo, hi});
    endtask : irq_is
    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, fire} = '0;
        {awaddr, araddr, wdata, wstrb, flags_one} = '0;
        prio = '0;
        req = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // registers sit on consecutive words from offset zero
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i));
            check(got, 32'h0);
        end
        rd(8'h18);
        check({30'h0, resp}, {30'h0, irq_bank_pkg::RESP_SLVERR});
        wr(8'h18, 8'hff, 1'b0);
        check({30'h0, resp}, {30'h0, irq_bank_pkg::RESP_SLVERR});
        for (int i = 0; i < 5; i++) begin
            wr(8'(4 * i), 8'hff, 1'b0);
            rd(8'(4 * i));
            check(got, {24'h0, masks[i]});
            wr(8'(4 * i), 8'h00, 1'b0);
        end
        foreach (rows[i]) begin
            logic [7:0] off;
            off = rows[i].three ? irq_bank_pkg::OFF_FLAGS_THREE : irq_bank_pkg::OFF_FLAGS_TWO;
            @(posedge clk);
            req <= mk(rows[i].code);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            repeat (3) @(posedge clk);
            rd(off);
            check(got, {24'h0, rows[i].exp});
            check({31'h0, irq_low}, 32'h0);
            wr(off, 8'h00, 1'b0);
        end
        wr(irq_bank_pkg::OFF_FLAGS_THREE, 8'h01, 1'b0);
        wr(irq_bank_pkg::OFF_ENABLES_THREE, 8'h01, 1'b0);
        irq_is(1'b0, 1'b0);
        wr(irq_bank_pkg::OFF_CONTROL, 8'h01, 1'b0);
        irq_is(1'b1, 1'b0);
        wr(irq_bank_pkg::OFF_ENABLES_THREE, 8'h00, 1'b0);
        irq_is(1'b0, 1'b0);
        flags_one <= 8'h40;
        wr(irq_bank_pkg::OFF_ENABLES_ONE, 8'h40, 1'b0);
        irq_is(1'b1, 1'b0);
        wr(irq_bank_pkg::OFF_ENABLES_ONE, 8'h00, 1'b0);
        prio.three <= 8'h01;
        wr(irq_bank_pkg::OFF_ENABLES_THREE, 8'h01, 1'b0);
        wr(irq_bank_pkg::OFF_CONTROL, 8'h02, 1'b0);
        irq_is(1'b0, 1'b1);
        prio.three <= 8'h00;
        irq_is(1'b0, 1'b0);
        wr(irq_bank_pkg::OFF_CONTROL, 8'h03, 1'b0);
        irq_is(1'b1, 1'b0);
        wr(irq_bank_pkg::OFF_CONTROL, 8'h00, 1'b0);
        // a software clear meeting a fresh event must not lose it
        req <= mk(11);
        wr(irq_bank_pkg::OFF_FLAGS_THREE, 8'h00, 1'b1);
        rd(irq_bank_pkg::OFF_FLAGS_THREE);
        check(got, 32'h1);
        wr(irq_bank_pkg::OFF_FLAGS_THREE, 8'h00, 1'b0);
        req.serial_b_rx_full <= 1'b1;
        wr(irq_bank_pkg::OFF_FLAGS_THREE, 8'h00, 1'b0);
        rd(irq_bank_pkg::OFF_FLAGS_THREE);
        check(got, 32'h20);
        req.serial_b_rx_full <= 1'b0;
        req.serial_b_tx_empty <= 1'b1;
        repeat (3) @(posedge clk);
        rd(irq_bank_pkg::OFF_FLAGS_THREE);
        check(got, 32'h10);
        final_report();
    end
endmodule : testbench
